// ===== pllc_consts.svh
// Constants of the reference-loss, bandwidth and ratio control block.
// Assumes a single 100 MHz internal oscillator clock drives all logic.
`ifndef PLLC_CONSTS_SVH
`define PLLC_CONSTS_SVH

`define PLLC_CNT_W 24
`define PLLC_RATIO_B3_ADDR 8'h06
`define PLLC_RATIO_B2_ADDR 8'h07
`define PLLC_RATIO_B1_ADDR 8'h08
`define PLLC_RATIO_B0_ADDR 8'h09
`define PLLC_RATIO_RESET 32'h0000_0000
`define PLLC_FMT_20_12 1'b0
`define PLLC_FMT_12_20 1'b1
`define PLLC_MOD_RESET 3'h0
`define PLLC_CLK_MHZ 100
`define PLLC_SKIP_GAP_US 20000
`define PLLC_LOSS_CYCLES 8388608
`define PLLC_ACQ_CYCLES 24'h000400
`define PLLC_TOL_SHIFT 3
`define PLLC_BW_WIDE_SHIFT 4'h1
`define PLLC_BW_MAX_SHIFT 4'ha

`endif

// ===== pllc_ctrl.sv
// Reference loss handling, loop bandwidth choice and effective ratio.
// Assumes refClkIn and synthClk are synchronous to core_clk; ratio bytes
// arrive from the control port as single-cycle byte writes.
`default_nettype none
`include "pllc_consts.svh"

module pllc_ctrl #(
  parameter int LOSS_TIMEOUT = `PLLC_LOSS_CYCLES,
  parameter int SKIP_GAP_CYCLES = `PLLC_SKIP_GAP_US * `PLLC_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic refClkIn,
  input wire logic synthClk,
  input wire logic regWrEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic skipToleranceEnable,
  input wire logic outputOnUnlockEnable,
  input wire logic [2:0] minLoopBwSelect,
  input wire logic ratioFormatSelect,
  input wire logic [2:0] modifierSelect,
  output logic pllLocked,
  output logic refMissing,
  output logic loopBwWide,
  output logic [3:0] loopGainShift,
  output logic [`PLLC_CNT_W-1:0] filtPeriod,
  output logic [31:0] effectiveRatioValue,
  output logic [19:0] effRatioInt,
  output logic [19:0] effRatioFrac,
  output logic pllClkOut
);

  // Skip gap limit is not enforced: past it the loop may drift unflagged
  localparam logic [`PLLC_CNT_W-1:0] SkipGap = `PLLC_CNT_W'(SKIP_GAP_CYCLES);

  // -----------------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------------
  logic rstMeta;
  logic rstSyncN;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0;
      rstSyncN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSyncN <= rstMeta;
    end
  end

  // -----------------------------------------------------------------
  // Gap counter
  // -----------------------------------------------------------------
  pllc_gap_if gap ();

  pllc_gap_counter #(
    .LOSS_TIMEOUT(LOSS_TIMEOUT)
  ) u_gap (
    .core_clk(core_clk),
    .rstN(rstSyncN),
    .gap(gap)
  );

  pllc_pkg::pllc_ctrl_s s_reg;
  pllc_pkg::pllc_ctrl_s s_next;

  logic refEdge;
  logic ratioWr;
  logic cfgChange;
  logic locked;
  logic [`PLLC_CNT_W:0] tol;
  logic [`PLLC_CNT_W:0] perHi;
  logic [`PLLC_CNT_W:0] perLo;
  logic [`PLLC_CNT_W:0] meas;
  logic perBad;
  logic [3:0] shift;
  logic signed [`PLLC_CNT_W:0] diff;
  logic signed [`PLLC_CNT_W:0] step;
  logic [31:0] effCalc;

  assign refEdge = refClkIn & ~s_reg.refPrev;
  assign gap.restart = refEdge;
  assign ratioWr = regWrEn && (regAddr >= `PLLC_RATIO_B3_ADDR)
                   && (regAddr <= `PLLC_RATIO_B0_ADDR);
  // A new fractional-N value forces a fresh acquisition
  assign cfgChange = ratioWr || (ratioFormatSelect != s_reg.fmt)
                     || (modifierSelect != s_reg.modSel);
  assign locked = (s_reg.st == pllc_pkg::PLLC_ST_LOCK)
                  || (s_reg.st == pllc_pkg::PLLC_ST_HOLD);

  // -----------------------------------------------------------------
  // Period window
  // -----------------------------------------------------------------
  always_comb begin
    tol = (`PLLC_CNT_W+1)'(s_reg.lastPer >> `PLLC_TOL_SHIFT);
    perHi = {1'b0, s_reg.lastPer} + tol;
    perLo = {1'b0, s_reg.lastPer} - tol;
    meas = {1'b0, gap.count};
    perBad = (meas > perHi) || (meas < perLo);
  end

  // -----------------------------------------------------------------
  // Loop bandwidth and jitter filter
  // -----------------------------------------------------------------
  always_comb begin
    if (locked) begin
      shift = `PLLC_BW_MAX_SHIFT - {1'b0, s_reg.bwSel};
    end else begin
      shift = `PLLC_BW_WIDE_SHIFT;
    end
    // Small shift tracks input wander; large shift smooths it away
    diff = $signed(meas) - $signed({1'b0, s_reg.filtPer});
    step = diff >>> shift;
  end

  // -----------------------------------------------------------------
  // Effective ratio
  // -----------------------------------------------------------------
  always_comb begin
    if (!s_reg.modSel[2]) begin
      effCalc = s_reg.ratio << s_reg.modSel[1:0];
    end else begin
      effCalc = s_reg.ratio >> ({1'b0, s_reg.modSel[1:0]} + 3'h1);
    end
  end

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.refPrev = refClkIn;
    s_next.fmt = ratioFormatSelect;
    s_next.modSel = modifierSelect;
    s_next.skipEn = skipToleranceEnable;
    s_next.outUnl = outputOnUnlockEnable;
    s_next.bwSel = minLoopBwSelect;
    s_next.eff = effCalc;
    if (s_reg.fmt == `PLLC_FMT_12_20) begin
      s_next.effInt = {8'h00, effCalc[31:20]};
      s_next.effFrac = effCalc[19:0];
    end else begin
      s_next.effInt = effCalc[31:12];
      s_next.effFrac = {effCalc[11:0], 8'h00};
    end
    if (regWrEn) begin
      unique case (regAddr)
        `PLLC_RATIO_B3_ADDR: s_next.ratio[31:24] = regWrData;
        `PLLC_RATIO_B2_ADDR: s_next.ratio[23:16] = regWrData;
        `PLLC_RATIO_B1_ADDR: s_next.ratio[15:8] = regWrData;
        `PLLC_RATIO_B0_ADDR: s_next.ratio[7:0] = regWrData;
        default: ;
      endcase
    end
    unique case (regAddr)
      `PLLC_RATIO_B3_ADDR: s_next.rdData = s_reg.ratio[31:24];
      `PLLC_RATIO_B2_ADDR: s_next.rdData = s_reg.ratio[23:16];
      `PLLC_RATIO_B1_ADDR: s_next.rdData = s_reg.ratio[15:8];
      `PLLC_RATIO_B0_ADDR: s_next.rdData = s_reg.ratio[7:0];
      default: s_next.rdData = 8'h00;
    endcase
    if (refEdge && s_reg.st != pllc_pkg::PLLC_ST_UNLOCK) begin
      s_next.filtPer = s_reg.filtPer + `PLLC_CNT_W'(step);
    end

    unique case (s_reg.st)
      pllc_pkg::PLLC_ST_UNLOCK: begin
        if (refEdge) begin
          s_next.havePer = 1'b1;
          if (s_reg.havePer) begin
            // Second edge gives the first period
            s_next.lastPer = gap.count;
            s_next.filtPer = gap.count;
            s_next.acqCnt = '0;
            s_next.st = pllc_pkg::PLLC_ST_ACQ;
          end
        end
      end
      pllc_pkg::PLLC_ST_ACQ: begin
        s_next.acqCnt = s_reg.acqCnt + `PLLC_CNT_W'(1);
        if (gap.expired) begin
          s_next.havePer = 1'b0;
          s_next.st = pllc_pkg::PLLC_ST_UNLOCK;
        end else if (refEdge && perBad) begin
          s_next.lastPer = gap.count;
          s_next.acqCnt = '0;
        end else if (s_reg.acqCnt >= `PLLC_ACQ_CYCLES - `PLLC_CNT_W'(1)) begin
          s_next.st = pllc_pkg::PLLC_ST_LOCK;
        end else if (refEdge) begin
          s_next.lastPer = gap.count;
        end
      end
      pllc_pkg::PLLC_ST_LOCK: begin
        if (refEdge) begin
          s_next.lastPer = gap.count;
          if (perBad) begin
            // Early or odd edge is a frequency change: unlock now
            s_next.acqCnt = '0;
            s_next.st = pllc_pkg::PLLC_ST_ACQ;
          end
        end else if (meas > perHi) begin
          s_next.st = pllc_pkg::PLLC_ST_HOLD;
        end
      end
      pllc_pkg::PLLC_ST_HOLD: begin
        if (refEdge) begin
          if (s_reg.skipEn) begin
            // Beyond the skip gap the loop may drift; nothing is flagged
            s_next.st = pllc_pkg::PLLC_ST_LOCK;
          end else begin
            s_next.acqCnt = '0;
            s_next.st = pllc_pkg::PLLC_ST_ACQ;
          end
        end else if (gap.expired) begin
          s_next.havePer = 1'b0;
          s_next.st = pllc_pkg::PLLC_ST_UNLOCK;
        end
      end
    endcase

    if (cfgChange && s_next.st != pllc_pkg::PLLC_ST_UNLOCK) begin
      s_next.acqCnt = '0;
      s_next.st = pllc_pkg::PLLC_ST_ACQ;
    end
    s_next.clkOut = synthClk & (locked | s_reg.outUnl);
  end

  always_ff @(posedge core_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      s_reg <= '0;
      s_reg.st <= pllc_pkg::PLLC_ST_UNLOCK;
      s_reg.ratio <= `PLLC_RATIO_RESET;
      s_reg.fmt <= `PLLC_FMT_20_12;
      s_reg.modSel <= `PLLC_MOD_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign regRdData = s_reg.rdData;
  assign pllLocked = locked;
  assign refMissing = (s_reg.st == pllc_pkg::PLLC_ST_HOLD);
  assign loopBwWide = !locked;
  assign loopGainShift = shift;
  assign filtPeriod = s_reg.filtPer;
  assign effectiveRatioValue = s_reg.eff;
  assign effRatioInt = s_reg.effInt;
  assign effRatioFrac = s_reg.effFrac;
  assign pllClkOut = s_reg.clkOut;

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSyncN);

  logic [31:0] ratioNow;
  logic [2:0] modNow;
  logic isHold;
  logic [7:0] ratioTop;
  assign ratioNow = s_reg.ratio;
  assign ratioTop = s_reg.ratio[31:24];
  assign modNow = s_reg.modSel;
  assign isHold = (s_reg.st == pllc_pkg::PLLC_ST_HOLD);

  sequence holdReturn;
    isHold && refEdge && !cfgChange;
  endsequence

  skip_keep_lock_a: assert property (
    holdReturn ##0 s_reg.skipEn |=> (s_reg.st == pllc_pkg::PLLC_ST_LOCK) && pllLocked)
    else $error("skip return did not keep lock");

  noskip_reacquire_a: assert property (
    holdReturn ##0 !s_reg.skipEn |=> (s_reg.st == pllc_pkg::PLLC_ST_ACQ) && loopBwWide)
    else $error("return without skip did not reacquire");

  timeout_unlock_a: assert property (
    isHold && gap.expired && !refEdge |=> !pllLocked ##1
      (pllClkOut == ($past(s_reg.outUnl) && $past(synthClk))))
    else $error("timeout did not unlock or gate output");

  glitch_unlock_a: assert property (
    (s_reg.st == pllc_pkg::PLLC_ST_LOCK) && refEdge && (meas < perLo) |=> !pllLocked)
    else $error("glitch edge did not unlock at once");

  unlock_low_a: assert property (
    !locked && !s_reg.outUnl |=> !pllClkOut)
    else $error("output toggled while unlocked");

  hold_output_a: assert property (
    isHold && synthClk |=> pllClkOut)
    else $error("output stopped during reference gap");

  gain_select_a: assert property (
    locked |-> loopGainShift == (`PLLC_BW_MAX_SHIFT - {1'b0, s_reg.bwSel}))
    else $error("locked loop not at selected bandwidth");

  mod_unity_a: assert property (
    modNow == 3'h0 |=> effectiveRatioValue == $past(ratioNow))
    else $error("unity modifier changed ratio");

  mod_sixteenth_a: assert property (
    modNow == 3'h7 |=> effectiveRatioValue == ($past(ratioNow) >> 4))
    else $error("modifier code 7 not divide by 16");

  fmt_hires_a: assert property (
    s_reg.fmt == `PLLC_FMT_12_20 |=> effRatioFrac == effectiveRatioValue[19:0])
    else $error("12.20 fraction split wrong");

  fmt_himul_a: assert property (
    s_reg.fmt == `PLLC_FMT_20_12 |=> effRatioInt == effectiveRatioValue[31:12])
    else $error("20.12 integer split wrong");

  ratio_store_a: assert property (
    regWrEn && regAddr == `PLLC_RATIO_B0_ADDR |=> ratioNow[7:0] == $past(regWrData))
    else $error("ratio low byte not stored");

  ratio_read_a: assert property (
    regAddr == `PLLC_RATIO_B3_ADDR |=> regRdData == $past(ratioTop))
    else $error("ratio high byte read back wrong");

  skip_drift_a: assert property (
    holdReturn ##0 (s_reg.skipEn && (meas > {1'b0, SkipGap})) |=> pllLocked && !refMissing)
    else $error("skip return past gap limit raised unlock");

  hold_enter_a: assert property (
    (s_reg.st == pllc_pkg::PLLC_ST_LOCK) && !refEdge && (meas > perHi) && !cfgChange
      |=> refMissing && pllLocked)
    else $error("clean reference loss did not hold output");

  // Acquisition ends after a fixed count unless an odd edge or a config change restarts it, or a gap timeout drops it to unlock
  sequence acqDone;
    (s_reg.st == pllc_pkg::PLLC_ST_ACQ) && (s_reg.acqCnt == `PLLC_ACQ_CYCLES - `PLLC_CNT_W'(1));
  endsequence

  acq_lock_a: assert property (
    acqDone ##0 (!gap.expired && !(refEdge && perBad) && !cfgChange) |=> pllLocked && !loopBwWide)
    else $error("acquisition did not end in lock");

endmodule : pllc_ctrl

`default_nettype wire

// ===== pllc_gap_counter.sv
// Cycles elapsed since the last reference edge, saturating at the loss timeout.
// Assumes restart is a one-cycle pulse per reference edge.
`default_nettype none
`include "pllc_consts.svh"

module pllc_gap_counter #(
  parameter int LOSS_TIMEOUT = `PLLC_LOSS_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstN,
  pllc_gap_if.cnt gap
);

  localparam logic [`PLLC_CNT_W-1:0] LossCnt = `PLLC_CNT_W'(LOSS_TIMEOUT);

  pllc_pkg::pllc_gap_s s_reg;
  pllc_pkg::pllc_gap_s s_next;

  // -----------------------------------------------------------------
  // Counter
  // -----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    if (gap.restart) begin
      s_next.count = '0;
    end else if (s_reg.count < LossCnt) begin
      s_next.count = s_reg.count + `PLLC_CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign gap.count = s_reg.count;
  assign gap.expired = (s_reg.count >= LossCnt);

  restart_clears_a: assert property (
    @(posedge core_clk) disable iff (!rstN)
    gap.restart |=> (gap.count == '0))
    else $error("gap count not cleared by reference edge");

  saturate_hold_a: assert property (
    @(posedge core_clk) disable iff (!rstN)
    (gap.expired && !gap.restart) |=> (gap.expired && $stable(gap.count)))
    else $error("expired gap count moved without an edge");

endmodule : pllc_gap_counter

`default_nettype wire

// ===== pllc_gap_if.sv
// Carrier between the controller and its reference gap counter.
// Assumes both ends share the internal oscillator clock.
`default_nettype none
`include "pllc_consts.svh"

interface pllc_gap_if;
  logic restart;
  logic [`PLLC_CNT_W-1:0] count;
  logic expired;
  modport ctl (output restart, input count, input expired);
  modport cnt (input restart, output count, output expired);
endinterface : pllc_gap_if

`default_nettype wire

// ===== pllc_pkg.sv
// Types shared by the control block and its gap counter.
// Assumes pllc_consts.svh is on the include path.
`default_nettype none
`include "pllc_consts.svh"

package pllc_pkg;

  typedef enum logic [1:0] {
    PLLC_ST_UNLOCK,
    PLLC_ST_ACQ,
    PLLC_ST_LOCK,
    PLLC_ST_HOLD
  } pllc_state_e;

  typedef struct packed {
    pllc_state_e st;
    logic [31:0] ratio;
    logic fmt;
    logic [2:0] modSel;
    logic skipEn;
    logic outUnl;
    logic [2:0] bwSel;
    logic refPrev;
    logic havePer;
    logic [`PLLC_CNT_W-1:0] lastPer;
    logic [`PLLC_CNT_W-1:0] acqCnt;
    logic [`PLLC_CNT_W-1:0] filtPer;
    logic [31:0] eff;
    logic [19:0] effInt;
    logic [19:0] effFrac;
    logic clkOut;
    logic [7:0] rdData;
  } pllc_ctrl_s;

  typedef struct packed {
    logic [`PLLC_CNT_W-1:0] count;
  } pllc_gap_s;

endpackage : pllc_pkg

`default_nettype wire

// ===== pllc_ref_src.sv
// Reference clock source model for the loss and skip control block.
// Assumes the bench drives run, glitch and period just after core_clk edges.
`default_nettype none

module pllc_ref_src (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic glitch,
  input wire logic [15:0] period,
  output var logic refClkIn
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] phaseReg;

  // Period is kept far below the skip gap, standing in for a slow reference
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phaseReg <= 16'h0000;
      refClkIn <= 1'b0;
    end else if (!run) begin
      // A removed source rests low, so no stray edge appears
      phaseReg <= 16'h0000;
      refClkIn <= 1'b0;
    end else if (glitch) begin
      // Restart the period early: next edge arrives out of step
      phaseReg <= 16'h0000;
      refClkIn <= 1'b0;
    end else begin
      phaseReg <= (phaseReg == period - 16'h0001) ? 16'h0000 : phaseReg + 16'h0001;
      refClkIn <= (phaseReg < (period >> 1));
    end
  end
endmodule : pllc_ref_src

`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the reference loss, bandwidth and ratio block.
// Assumes the design files and pllc_ref_src are compiled before this file.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk, nrst, refRun, glitchReq, synthClk, regWrEn;
  logic [7:0] regAddr, regWrData, regRdData;
  logic skipEn, outUnl, fmtSel, pllLocked, refMissing, loopBwWide, pllClkOut, refClkIn;
  logic [2:0] bwSel, modSel;
  logic [3:0] loopGainShift;
  logic [31:0] effVal;
  logic [19:0] effInt, effFrac;
  logic [23:0] filtPeriod;
  int badCount, checks;
  localparam logic [31:0] RATIO = 32'h0012_3450;

  pllc_ctrl #(.LOSS_TIMEOUT(200), .SKIP_GAP_CYCLES(100)) dut_u (
    .core_clk(core_clk), .nrst(nrst), .refClkIn(refClkIn), .synthClk(synthClk),
    .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .skipToleranceEnable(skipEn), .outputOnUnlockEnable(outUnl),
    .minLoopBwSelect(bwSel), .ratioFormatSelect(fmtSel), .modifierSelect(modSel),
    .pllLocked(pllLocked), .refMissing(refMissing), .loopBwWide(loopBwWide),
    .loopGainShift(loopGainShift), .filtPeriod(filtPeriod), .effectiveRatioValue(effVal),
    .effRatioInt(effInt), .effRatioFrac(effFrac), .pllClkOut(pllClkOut)
  );

  pllc_ref_src ref_u (
    .core_clk(core_clk), .nrst(nrst), .run(refRun), .glitch(glitchReq),
    .period(16'h0010), .refClkIn(refClkIn)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Free running stand-in for the synthesizer output
  always @(posedge core_clk) synthClk <= ~synthClk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    regAddr <= a;
    @(posedge core_clk);
    @(negedge core_clk);
    check("regRdData", regRdData, e);
  endtask : rd

  task automatic wait_lock(input logic lvl, input int maxc);
    int n;
    n = 0;
    while (pllLocked !== lvl && n < maxc) begin
      @(negedge core_clk);
      n++;
    end
    check("pllLocked", pllLocked, lvl);
  endtask : wait_lock

  // Output either follows the synthesizer one cycle late or rests low
  task automatic gate_check(input logic run);
    logic e;
    repeat (4) begin
      @(negedge core_clk);
      e = run & ~synthClk;
      check("pllClkOut", pllClkOut, e);
    end
  endtask : gate_check

  task automatic stop_ref;
    @(posedge refClkIn);
    @(posedge core_clk);
    refRun <= 1'b0;
  endtask : stop_ref

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    check("loopBwWide", loopBwWide, 1'b1);
    check("loopGainShift", loopGainShift, 4'h1);
    check("effVal", effVal, 32'h0);
    rd(8'h06, 8'h00);
  endtask : t_reset

  task automatic t_regs;
    @(posedge core_clk);
    regWrEn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      regAddr <= 8'h06 + 8'(i);
      regWrData <= RATIO[31 - 8 * i -: 8];
      @(posedge core_clk);
    end
    regWrEn <= 1'b0;
    wr(8'h0b, 8'hee);
    for (int i = 0; i < 4; i++) rd(8'h06 + 8'(i), RATIO[31 - 8 * i -: 8]);
    rd(8'h0a, 8'h00);
  endtask : t_regs

  task automatic t_mod;
    logic [31:0] e;
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk);
      modSel <= 3'(k);
      repeat (3) @(posedge core_clk);
      @(negedge core_clk);
      e = (k < 4) ? RATIO << k : RATIO >> (k - 3);
      check("effVal", effVal, e);
      rd(8'h09, 8'h50);
    end
    @(posedge core_clk);
    modSel <= 3'h0;
  endtask : t_mod

  task automatic t_fmt;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check("effInt", effInt, RATIO[31:12]);
    check("effFrac", effFrac, {RATIO[11:0], 8'h00});
    @(posedge core_clk);
    fmtSel <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check("effInt", effInt, {8'h00, RATIO[31:20]});
    check("effFrac", effFrac, RATIO[19:0]);
  endtask : t_fmt

  task automatic t_lock;
    @(posedge core_clk);
    refRun <= 1'b1;
    repeat (900) @(posedge core_clk);
    @(negedge core_clk);
    check("pllLocked", pllLocked, 1'b0);
    check("loopBwWide", loopBwWide, 1'b1);
    wait_lock(1'b1, 400);
    check("loopBwWide", loopBwWide, 1'b0);
    check("loopGainShift", loopGainShift, 4'h7);
    check("filtPeriod", filtPeriod, 32'h0000_000f);
    gate_check(1'b1);
  endtask : t_lock

  task automatic t_loss;
    stop_ref();
    repeat (140) @(posedge core_clk);
    @(negedge core_clk);
    check("refMissing", refMissing, 1'b1);
    check("pllLocked", pllLocked, 1'b1);
    gate_check(1'b1);
    wait_lock(1'b0, 100);
    gate_check(1'b0);
    @(posedge core_clk);
    refRun <= 1'b1;
    repeat (500) @(posedge core_clk);
    @(negedge core_clk);
    check("pllLocked", pllLocked, 1'b0);
    wait_lock(1'b1, 1000);
  endtask : t_loss

  task automatic t_gap(input logic skip, input int gap);
    int drops;
    drops = 0;
    @(posedge core_clk);
    skipEn <= skip;
    stop_ref();
    repeat (gap - 10) @(posedge core_clk);
    @(negedge core_clk);
    check("refMissing", refMissing, 1'b1);
    check("pllLocked", pllLocked, 1'b1);
    @(posedge core_clk);
    refRun <= 1'b1;
    repeat (30) @(posedge core_clk);
    @(negedge core_clk);
    check("pllLocked", pllLocked, skip);
    gate_check(skip);
    repeat (1300) begin
      @(negedge core_clk);
      if (pllLocked !== 1'b1) drops++;
    end
    check("unlockedAfterGap", drops > 0, !skip);
    check("pllLocked", pllLocked, 1'b1);
  endtask : t_gap

  task automatic t_glitch;
    @(posedge core_clk);
    outUnl <= 1'b1;
    @(posedge refClkIn);
    repeat (9) @(posedge core_clk);
    glitchReq <= 1'b1;
    @(posedge core_clk);
    glitchReq <= 1'b0;
    wait_lock(1'b0, 10);
    gate_check(1'b1);
    @(posedge core_clk);
    outUnl <= 1'b0;
    wait_lock(1'b1, 1400);
  endtask : t_glitch

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    {nrst, refRun, glitchReq, synthClk, regWrEn, skipEn, outUnl, fmtSel} = 8'h00;
    regAddr = 8'h00;
    regWrData = 8'h00;
    bwSel = 3'h3;
    modSel = 3'h0;
    badCount = 0;
    checks = 0;
    repeat (12) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_regs();
    t_mod();
    t_fmt();
    t_lock();
    t_loss();
    t_gap(1'b0, 60);
    t_gap(1'b1, 60);
    t_gap(1'b1, 150);
    t_glitch();
    end_of_test();
  end

  // Whole run needs roughly 7700 cycles
  initial begin
    repeat (40000) @(posedge core_clk);
    badCount++;
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
